// [hw/mrr_pkg.sv]
// Constants for the register-read path
package mrr_pkg;
   localparam int CLK_PERIOD_PS = 10000;
   localparam int CLK_KHZ = 100000;
   localparam int DQ_W = 32;
   localparam int CA_W = 10;
   localparam int MA_W = 8;
   localparam int RL_W = 4;
   localparam int BURST_BEATS = 4;
   localparam int REG_READ_PERIOD = 2;
   localparam int STROBE_ACCESS_PS = 5500;
   localparam int STROBE_CYC =
      (STROBE_ACCESS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TEMP_UPDATE_MS = 32;
   localparam int TEMP_UPDATE_CYC = TEMP_UPDATE_MS * CLK_KHZ;
   localparam logic [3:0] CMD_REG_READ = 4'h8;
   localparam logic [MA_W-1:0] MA_TEMP_STATUS = 8'h04;
   localparam logic [MA_W-1:0] MA_CAL_A = 8'h20;
   localparam logic [MA_W-1:0] MA_CAL_B = 8'h28;
   localparam logic [3:0] CAL_A_BEATS = 4'h5;
   localparam logic [3:0] CAL_B_BEATS = 4'hC;
   localparam logic [2:0] TEMP_RESET = 3'h0;
   localparam logic [7:0] OTHER_REG_VALUE = 8'h00;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_BURST = 2'b10
   } rd_state_e;
endpackage : mrr_pkg

// [hw/mrr_readout.sv]
// Register-read decode and four-beat readout burst
`timescale 1ns/1ps
module mrr_readout #(
   parameter int UPDATE_CYC = mrr_pkg::TEMP_UPDATE_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clk_en,
   // Command/address pins
   input wire logic cs_n,
   input wire logic [mrr_pkg::CA_W-1:0] ca_rise,
   input wire logic [mrr_pkg::CA_W-1:0] ca_fall,
   // Configuration and status from device logic
   input wire logic [mrr_pkg::RL_W-1:0] read_latency,
   input wire logic banks_active,
   input wire logic lp_exit,
   input wire logic [2:0] temp_code,
   // Data and strobe pins, bank-activity status
   output logic [mrr_pkg::DQ_W-1:0] dq_out,
   output logic dq_oe,
   output logic [mrr_pkg::DQ_W/8-1:0] dqs_out,
   output logic dqs_oe,
   output logic banks_active_out
);
   import mrr_pkg::*;
   localparam int SW = 1 + 2 * CA_W;
   localparam int WW = RL_W + 2;

   function automatic logic is_cal(input logic [MA_W-1:0] a);
      return a == MA_CAL_A || a == MA_CAL_B;
   endfunction : is_cal

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [SW-1:0] pin_s1;
   logic [SW-1:0] pin_s2;
   logic cs_n_s;
   logic [CA_W-1:0] ca_r;
   logic [CA_W-1:0] ca_f;
   assign {cs_n_s, ca_r, ca_f} = pin_s2;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pin_s1 <= {1'b1, {(SW-1){1'b0}}};
         pin_s2 <= {1'b1, {(SW-1){1'b0}}};
      end else if (clk_en) begin
         pin_s1 <= {cs_n, ca_rise, ca_fall};
         pin_s2 <= pin_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Temperature status keeper
   temp_link_if tlink ();
   assign tlink.lp_exit = lp_exit;

   temp_status_keeper #(.UPDATE_CYC(UPDATE_CYC)) u_temp (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .clk_en(clk_en),
      .temp_code(temp_code),
      .link(tlink)
   );

   ////////////////////////////////////////////////////////////////////////
   // Command decode
   logic cmd_hit;
   logic [MA_W-1:0] cmd_addr;
   assign cmd_hit = !cs_n_s && ca_r[3:0] == CMD_REG_READ;
   assign cmd_addr = {ca_r[9:4], ca_f[1:0]};

   ////////////////////////////////////////////////////////////////////////
   // Readout sequencer
   rd_state_e state;
   rd_state_e next_state;
   logic [WW-1:0] wait_cnt;
   logic [WW-1:0] next_wait_cnt;
   logic [1:0] beat;
   logic [1:0] next_beat;
   logic [MA_W-1:0] addr;
   logic [MA_W-1:0] next_addr;
   logic [DQ_W-1:0] next_dq_out;
   logic next_dq_oe;
   logic [DQ_W/8-1:0] next_dqs_out;
   logic [7:0] reg_byte;
   logic [3:0] pattern;

   always_comb begin
      unique case (addr)
         MA_TEMP_STATUS: reg_byte = {5'h00, tlink.status};
         default: reg_byte = OTHER_REG_VALUE;
      endcase
      pattern = (addr == MA_CAL_A) ? CAL_A_BEATS : CAL_B_BEATS;
   end

   always_comb begin
      next_state = state;
      next_wait_cnt = wait_cnt;
      next_beat = beat;
      next_addr = addr;
      unique case (state)
         ST_IDLE: begin
            // Accepted whether banks are open or idle
            if (cmd_hit) begin
               next_state = ST_WAIT;
               next_addr = cmd_addr;
               next_wait_cnt = WW'(read_latency) + WW'(STROBE_CYC - 1);
            end
         end
         ST_WAIT: begin
            if (wait_cnt == '0) begin
               next_state = ST_BURST;
               next_beat = 2'h0;
            end else begin
               next_wait_cnt = wait_cnt - WW'(1);
            end
         end
         ST_BURST: begin
            // Commands ignored until the burst is done
            next_beat = beat + 2'h1;
            if (beat == 2'(BURST_BEATS - 1)) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
      next_dq_oe = next_state == ST_BURST;
      next_dqs_out = {(DQ_W/8){next_dq_oe && !next_beat[0]}};
      next_dq_out = '0;
      if (next_dq_oe) begin
         if (is_cal(addr)) begin
            next_dq_out = {DQ_W{pattern[next_beat]}};
         end else if (next_beat == 2'h0) begin
            next_dq_out = {{(DQ_W-8){1'b0}}, reg_byte};
         end
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state <= ST_IDLE;
         wait_cnt <= '0;
         beat <= 2'h0;
         addr <= '0;
         dq_out <= '0;
         dq_oe <= 1'b0;
         dqs_out <= '0;
      end else if (clk_en) begin
         state <= next_state;
         wait_cnt <= next_wait_cnt;
         beat <= next_beat;
         addr <= next_addr;
         dq_out <= next_dq_out;
         dq_oe <= next_dq_oe;
         dqs_out <= next_dqs_out;
      end
   end

   assign dqs_oe = dq_oe;
   assign banks_active_out = banks_active;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   logic [WW:0] since_cmd;
   logic [WW-1:0] lat_hold;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         since_cmd <= '0;
         lat_hold <= '0;
      end else if (clk_en) begin
         if (state == ST_IDLE && cmd_hit) begin
            since_cmd <= (WW+1)'(1);
            lat_hold <= WW'(read_latency) + WW'(STROBE_CYC);
         end else if (since_cmd != '0) begin
            since_cmd <= since_cmd + (WW+1)'(1);
         end
      end
   end

   property p_accept;
      @(posedge ref_clk) disable iff (!resetn || !clk_en)
      state == ST_IDLE && cmd_hit
         |=> state == ST_WAIT && addr == $past(cmd_addr);
   endproperty
   a_accept: assert property (p_accept)
      else $error("register-read command not accepted");

   property p_latency;
      @(posedge ref_clk) disable iff (!resetn || !clk_en)
      $rose(dq_oe) |-> since_cmd == (WW+1)'(lat_hold) + (WW+1)'(1);
   endproperty
   a_latency: assert property (p_latency)
      else $error("first beat at wrong latency");

   property p_four_beats;
      @(posedge ref_clk) disable iff (!resetn || !clk_en)
      $rose(dq_oe) |-> dq_oe [*4] ##1 !dq_oe;
   endproperty
   a_four_beats: assert property (p_four_beats)
      else $error("burst not four beats");

   property p_strobe_toggle;
      @(posedge ref_clk) disable iff (!resetn || !clk_en)
      dq_oe && $past(dq_oe) |-> dqs_out == ~$past(dqs_out) && dqs_oe;
   endproperty
   a_strobe_toggle: assert property (p_strobe_toggle)
      else $error("strobe did not toggle");

   property p_first_byte;
      @(posedge ref_clk) disable iff (!resetn || !clk_en)
      $rose(dq_oe) && addr == MA_TEMP_STATUS
         |-> dq_out == {{(DQ_W-3){1'b0}}, $past(tlink.status)};
   endproperty
   a_first_byte: assert property (p_first_byte)
      else $error("temperature byte wrong in first beat");

   property p_filler;
      @(posedge ref_clk) disable iff (!resetn || !clk_en)
      dq_oe && !is_cal(addr) |-> dq_out[DQ_W-1:8] == '0;
   endproperty
   a_filler: assert property (p_filler)
      else $error("upper data bits not filler");

   property p_cal_a;
      @(posedge ref_clk) disable iff (!resetn || !clk_en)
      $rose(dq_oe) && addr == MA_CAL_A |-> dq_out == '1 ##1 dq_out == '0
         ##1 dq_out == '1 ##1 dq_out == '0;
   endproperty
   a_cal_a: assert property (p_cal_a)
      else $error("calibration pattern A wrong");

   property p_cal_b;
      @(posedge ref_clk) disable iff (!resetn || !clk_en)
      $rose(dq_oe) && addr == MA_CAL_B |-> dq_out == '0 ##1 dq_out == '0
         ##1 dq_out == '1 ##1 dq_out == '1;
   endproperty
   a_cal_b: assert property (p_cal_b)
      else $error("calibration pattern B wrong");

   property p_lanes;
      @(posedge ref_clk) disable iff (!resetn || !clk_en)
      dq_oe && is_cal(addr) |-> dq_out == {DQ_W{dq_out[0]}};
   endproperty
   a_lanes: assert property (p_lanes)
      else $error("calibration lanes differ");
endmodule : mrr_readout

// [hw/temp_link_if.sv]
// Temperature status link between sensor logic and read path
`timescale 1ns/1ps
interface temp_link_if;
   logic [2:0] status;
   logic lp_exit;
   modport sensor (output status, input lp_exit);
   modport reader (input status, output lp_exit);
endinterface : temp_link_if

// [hw/temp_status_keeper.sv]
// Periodic capture of the on-die temperature code
`timescale 1ns/1ps
module temp_status_keeper #(
   parameter int UPDATE_CYC = mrr_pkg::TEMP_UPDATE_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clk_en,
   // Sensor pin and link
   input wire logic [2:0] temp_code,
   temp_link_if.sensor link
);
   import mrr_pkg::*;
   localparam int CW = $clog2(UPDATE_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(UPDATE_CYC - 1);
   logic [2:0] code_s1;
   logic [2:0] code_s2;
   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic [2:0] status;
   logic [2:0] next_status;

   always_comb begin
      next_cnt = cnt - CW'(1);
      next_status = status;
      if (cnt == '0 || link.lp_exit) begin
         next_cnt = LAST;
         next_status = code_s2;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         code_s1 <= TEMP_RESET;
         code_s2 <= TEMP_RESET;
         cnt <= '0;
         status <= TEMP_RESET;
      end else if (clk_en) begin
         code_s1 <= temp_code;
         code_s2 <= code_s1;
         cnt <= next_cnt;
         status <= next_status;
      end
   end

   assign link.status = status;

   ////////////////////////////////////////////////////////////////////////
   property p_interval;
      @(posedge ref_clk) disable iff (!resetn || !clk_en)
      cnt == '0 |=> cnt == LAST && status == $past(code_s2);
   endproperty
   a_interval: assert property (p_interval)
      else $error("temperature update interval exceeded");

   property p_exit_fresh;
      @(posedge ref_clk) disable iff (!resetn || !clk_en)
      link.lp_exit |=> status == $past(code_s2);
   endproperty
   a_exit_fresh: assert property (p_exit_fresh)
      else $error("status not refreshed on low-power exit");
endmodule : temp_status_keeper

// [sim/ctrl_model.sv]
// Controller model driving register-read commands
`timescale 1ns/1ps
module ctrl_model (
   // Clock
   input wire logic ref_clk,
   // Command/address pins
   output logic cs_n,
   output logic [mrr_pkg::CA_W-1:0] ca_rise,
   output logic [mrr_pkg::CA_W-1:0] ca_fall
);
   import mrr_pkg::*;
   initial begin
      cs_n = 1'b1;
      ca_rise = 10'h000;
      ca_fall = 10'h000;
   end
   ////////////////////////////////////////////////////////////////////
   // One command cycle, then no-operation cycles; caller at falling edge
   task automatic send(input logic [MA_W-1:0] a, input logic [3:0] code);
      cs_n = 1'b0;
      ca_rise = {a[7:2], code};
      ca_fall = {~ca_fall[9:2], a[1:0]};
      for (int i = 0; i < REG_READ_PERIOD; i++) begin
         @(negedge ref_clk);
         cs_n = 1'b1;
         ca_rise = ~ca_rise;
         ca_fall = ~ca_fall;
      end
   endtask : send
endmodule : ctrl_model

// [sim/sdram_mode_register_readout_bench.sv]
// Self-checking bench for the register-read path
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
   total_checks++; \
   if ((got) !== (ex)) begin \
      num_errors++; \
      $display("Error %s expected %h seen %h", nm, ex, got); \
   end \
end
module sdram_mode_register_readout_bench;
   import mrr_pkg::*;
   localparam int UPD = 2000;
   localparam logic [3:0] PAT_A = 4'h5;
   localparam logic [3:0] PAT_B = 4'hC;
   typedef struct {int cyc; logic [DQ_W-1:0] dq; logic [3:0] dqs;} note_s;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic cs_n;
   logic [CA_W-1:0] ca_rise, ca_fall;
   logic [RL_W-1:0] read_latency = 4'h1;
   logic banks_active = 1'b0;
   logic lp_exit = 1'b0;
   logic clk_en = 1'b1;
   logic [2:0] temp_code, exp_temp;
   logic [DQ_W-1:0] dq_out;
   logic [DQ_W/8-1:0] dqs_out;
   logic dq_oe, dqs_oe, banks_active_out;
   logic [31:0] seed = 32'h955910A6;
   logic [7:0] ra;
   int num_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   note_s notes[$];
   note_s m;
   ////////////////////////////////////////////////////////////////////
   mrr_readout #(.UPDATE_CYC(UPD)) dut (.ref_clk(ref_clk),
      .resetn(resetn), .clk_en(clk_en), .cs_n(cs_n), .ca_rise(ca_rise),
      .ca_fall(ca_fall), .read_latency(read_latency),
      .banks_active(banks_active), .lp_exit(lp_exit),
      .temp_code(temp_code), .dq_out(dq_out), .dq_oe(dq_oe),
      .dqs_out(dqs_out), .dqs_oe(dqs_oe),
      .banks_active_out(banks_active_out));
   ctrl_model ctl (.ref_clk(ref_clk), .cs_n(cs_n), .ca_rise(ca_rise),
      .ca_fall(ca_fall));
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) cyc <= cyc + 1;
   ////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic idle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : idle
   // Notes four beats and issues the command; hold counts frozen cycles
   task automatic rd_start(input logic [MA_W-1:0] a, input int hold);
      note_s n;
      for (int i = 0; i < BURST_BEATS; i++) begin
         n.cyc = cyc + 4 + int'(read_latency) + hold + i;
         n.dq = 32'h0;
         if (i == 0 && a == MA_TEMP_STATUS) n.dq = {29'h0, exp_temp};
         if (a == MA_CAL_A) n.dq = {DQ_W{PAT_A[i]}};
         if (a == MA_CAL_B) n.dq = {DQ_W{PAT_B[i]}};
         n.dqs = i[0] ? 4'h0 : 4'hF;
         notes.push_back(n);
      end
      ctl.send(a, CMD_REG_READ);
   endtask : rd_start
   // Full register read that waits out the burst
   task automatic rd(input logic [MA_W-1:0] a);
      rd_start(a, 0);
      idle(int'(read_latency) + 10);
   endtask : rd
   task automatic new_temp();
      temp_code = temp_code + 3'(rnd() % 7 + 1);
   endtask : new_temp
   task automatic close_out();
      `CHK("beats left", 0, notes.size())
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////////
   // Takes the oldest note at each beat
   always @(negedge ref_clk) begin
      if (resetn && dq_oe === 1'b1) begin
         if (notes.size() == 0) begin
            `CHK("spare beat", 1'b0, 1'b1)
         end else begin
            m = notes.pop_front();
            `CHK("beat time", m.cyc, cyc)
            `CHK("dq", m.dq, dq_out)
            `CHK("dqs", m.dqs, dqs_out)
            `CHK("dqs_oe", 1'b1, dqs_oe)
         end
      end else if (resetn) begin
         `CHK("idle outputs", 37'h0, {dqs_oe, dqs_out, dq_out})
      end
   end
   initial begin
      #300000;
      num_errors++;
      close_out();
   end
   initial begin
      temp_code = 3'(rnd());
      exp_temp = temp_code;
      idle(8);
      resetn = 1'b1;
      idle(2);
      lp_exit = 1'b1;
      idle(1);
      lp_exit = 1'b0;
      for (int k = 0; k < 8; k++) begin
         read_latency = 4'(rnd() % 15 + 1);
         banks_active = rnd() & 1;
         #1 `CHK("banks", banks_active, banks_active_out)
         ra = 8'(rnd());
         if (ra == 8'h04 || ra == 8'h20 || ra == 8'h28) ra ^= 8'h01;
         idle(1);
         rd(MA_TEMP_STATUS);
         rd(MA_CAL_A);
         rd(MA_CAL_B);
         rd(8'h05);
         rd(ra);
      end
      lp_exit = 1'b1;
      idle(1);
      lp_exit = 1'b0;
      new_temp();
      idle(UPD + 5);
      exp_temp = temp_code;
      rd(MA_TEMP_STATUS);
      new_temp();
      idle(4);
      lp_exit = 1'b1;
      idle(1);
      lp_exit = 1'b0;
      idle(3);
      exp_temp = temp_code;
      rd(MA_TEMP_STATUS);
      read_latency = 4'h4;
      ctl.send(MA_CAL_A, 4'h0);
      idle(1);
      ctl.send(MA_CAL_A, 4'h9);
      idle(20);
      rd_start(MA_CAL_B, 0);
      idle(int'(read_latency) + 2);
      ctl.send(MA_CAL_A, CMD_REG_READ);
      idle(20);
      rd_start(MA_TEMP_STATUS, 3);
      clk_en = 1'b0;
      idle(3);
      clk_en = 1'b1;
      idle(20);
      close_out();
   end
endmodule : sdram_mode_register_readout_bench
